// ===== rtl/sss_pkg.sv
// Shared constants for the sleep sync scheduler
package sss_pkg;

    // Clock rate and derived counts
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int TICK_W = 14;
    localparam logic [TICK_W-1:0] TICK_MAX = 14'h270f;

    // Propagation time per slot hop repeat, in ms
    localparam int PROP_UNIT_MS = 18;

    // Button timing, in ms
    localparam int HOLD_WAKE_MS = 2000;
    localparam int STAY_AWAKE_MS = 30000;
    localparam int DOUBLE_GAP_MS = 500;
    localparam logic [15:0] HOLD_WAKE_T = 16'h07d0;
    localparam logic [15:0] STAY_AWAKE_T = 16'h7530;
    localparam logic [15:0] DOUBLE_GAP_T = 16'h01f4;

    // Sleep mode selections
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_SUPPORT = 4'h7;
    localparam logic [3:0] MODE_CYCLIC = 4'h8;

    // Sleep option bit positions
    localparam int OPT_PREF_COORD = 0;
    localparam int OPT_NON_COORD = 1;
    localparam int OPT_EARLY_WAKE = 2;

    // Guard base, and guard and early wake steps per missed cycle, in ms
    localparam logic [15:0] GUARD_BASE_MS = 16'h0005;
    localparam logic [15:0] GUARD_STEP_MS = 16'h0005;
    localparam logic [15:0] EARLY_STEP_MS = 16'h000a;

    // LED blink half periods, in ms
    localparam logic [15:0] LED_SLOW_MS = 16'h03e8;
    localparam logic [15:0] LED_FAST_MS = 16'h00fa;

    // Reset values
    localparam logic [7:0] MISSED_RST = 8'h00;
    localparam logic [15:0] PERIOD_RST = 16'h0000;

    // Scheduler states
    typedef enum logic [3:0] {
        SSS_IDLE = 4'b0001,
        SSS_WAKE = 4'b0010,
        SSS_SLEEP = 4'b0100,
        SSS_AWAKE = 4'b1000
    } sss_state_t;

endpackage : sss_pkg

// ===== rtl/sss_button.sv
// Commissioning button decoder: single, double press and long hold
`timescale 1ns/1ps
module sss_button
    import sss_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Millisecond tick and synchronised button level
    input wire logic ms_tick_i,
    input wire logic btn_i,
    // Decoded events
    output logic single_o,
    output logic double_o,
    output logic hold_o
);

    logic btn_d_ff;
    logic pending_ff;
    logic held_done_ff;
    logic [15:0] gap_ff;
    logic [15:0] hold_ff;
    logic press;

    assign press = btn_i & ~btn_d_ff;

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            btn_d_ff <= 1'b0;
        else
            btn_d_ff <= btn_i;
    end

    // Press pairing within the gap window
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pending_ff <= 1'b0;
            gap_ff <= 16'h0000;
            single_o <= 1'b0;
            double_o <= 1'b0;
        end
        else
        begin
            single_o <= 1'b0;
            double_o <= 1'b0;
            if (press && pending_ff)
            begin
                pending_ff <= 1'b0;
                double_o <= 1'b1;
            end
            else if (press)
            begin
                pending_ff <= 1'b1;
                gap_ff <= 16'h0000;
            end
            else if (pending_ff && ms_tick_i)
            begin
                if (gap_ff >= DOUBLE_GAP_T)
                begin
                    pending_ff <= 1'b0;
                    single_o <= 1'b1;
                end
                else
                    gap_ff <= gap_ff + 16'h0001;
            end
        end
    end

    // Long hold detection, once per hold
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            hold_ff <= 16'h0000;
            held_done_ff <= 1'b0;
            hold_o <= 1'b0;
        end
        else
        begin
            hold_o <= 1'b0;
            if (!btn_i)
            begin
                hold_ff <= 16'h0000;
                held_done_ff <= 1'b0;
            end
            else if (ms_tick_i && !held_done_ff)
            begin
                if (hold_ff >= HOLD_WAKE_T - 16'h0001)
                begin
                    hold_o <= 1'b1;
                    held_done_ff <= 1'b1;
                end
                else
                    hold_ff <= hold_ff + 16'h0001;
            end
        end
    end

endmodule : sss_button

// ===== rtl/sss_sched.sv
// Sleep synchronisation scheduler for one mesh node
`timescale 1ns/1ps
// How it works
// - Guard time grows with missed sync cycles
// - Early wake shortens sleep when option set
// - Raise wake setting to computed minimum
// - Start non-sleeping; only modes 7, 8 sync
// - Double press makes node coordinator
// - LED slow as coordinator, fast when synced and awake
// - Single press wakes a sleeping synced node
// - Unsynced node requests sync then sleeps
// - Synced node answers sync requests
// - Support node never sleeps
// - Two second hold wakes for thirty seconds
// - Changed periods make node coordinator
// - Adopt new periods once sync sent
// - Missed new sync keeps old periods
// - Support node corrects outdated sync
// - Preferred coordinator syncs every wake cycle
module sss_sched
    import sss_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Configuration
    input wire logic [3:0] sleep_mode_select_i,
    input wire logic [7:0] sleep_options_i,
    input wire logic [15:0] sleep_period_setting_i,
    input wire logic [15:0] wake_time_setting_i,
    input wire logic [7:0] delay_slot_count_i,
    input wire logic [7:0] hop_limit_i,
    input wire logic [3:0] broadcast_repeat_count_i,
    // Received radio events
    input wire logic rx_sync_i,
    input wire logic [15:0] rx_sleep_i,
    input wire logic [15:0] rx_wake_i,
    input wire logic [7:0] rx_epoch_i,
    input wire logic rx_req_i,
    // Commissioning button pin
    input wire logic button_i,
    // Transmit requests
    output logic tx_sync_o,
    output logic tx_req_o,
    output logic [15:0] tx_sleep_o,
    output logic [15:0] tx_wake_o,
    output logic [7:0] tx_epoch_o,
    // Status
    output logic awake_o,
    output logic coord_o,
    output logic synced_o,
    output logic led_o,
    output logic [15:0] wake_eff_o,
    output logic [15:0] guard_o,
    output logic [7:0] missed_o
);

    sss_state_t state_ff;
    logic [TICK_W-1:0] tick_ff;
    logic ms_tick;
    logic btn_s1_ff;
    logic btn_s2_ff;
    logic btn_single;
    logic btn_double;
    logic btn_hold;
    logic [15:0] net_sleep_ff;
    logic [15:0] net_wake_ff;
    logic [15:0] cfg_sleep_ff;
    logic [15:0] cfg_wake_ff;
    logic [7:0] slots_ff;
    logic [7:0] hops_ff;
    logic [15:0] timer_ff;
    logic [15:0] stay_ff;
    logic [15:0] led_cnt_ff;
    logic pend_change_ff;
    logic sync_seen_ff;
    logic [15:0] min_wake;
    logic [15:0] guard;
    logic [15:0] sleep_len;
    logic [15:0] early;
    logic sleep_mode;
    logic cfg_change;
    logic sync_ok;
    logic stale_sync;

    ////////////////////////////////////////////////////////////////////////
    // Millisecond tick and button synchroniser

    assign ms_tick = (tick_ff == TICK_MAX);

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            tick_ff <= '0;
        else if (ms_tick)
            tick_ff <= '0;
        else
            tick_ff <= tick_ff + 14'h0001;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            btn_s1_ff <= 1'b0;
            btn_s2_ff <= 1'b0;
        end
        else
        begin
            btn_s1_ff <= button_i;
            btn_s2_ff <= btn_s1_ff;
        end
    end

    sss_button u_button (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .ms_tick_i(ms_tick),
        .btn_i(btn_s2_ff),
        .single_o(btn_single),
        .double_o(btn_double),
        .hold_o(btn_hold)
    );

    ////////////////////////////////////////////////////////////////////////
    // Derived timing

    assign sleep_mode = (sleep_mode_select_i == MODE_SUPPORT) ||
                        (sleep_mode_select_i == MODE_CYCLIC);
    // Propagation estimate doubles as wake minimum
    assign min_wake = 16'(16'(delay_slot_count_i) * 16'(hop_limit_i) *
                      16'({1'b0, broadcast_repeat_count_i} + 5'h01) *
                      16'(PROP_UNIT_MS));
    assign guard = GUARD_BASE_MS + 16'(GUARD_STEP_MS * 16'(missed_o));
    assign early = sleep_options_i[OPT_EARLY_WAKE] ?
                   16'(EARLY_STEP_MS * 16'(missed_o)) : 16'h0000;
    assign sleep_len = (early >= net_sleep_ff) ? 16'h0001 :
                       net_sleep_ff - early;
    assign cfg_change = (sleep_period_setting_i != cfg_sleep_ff) ||
                        (delay_slot_count_i != slots_ff) ||
                        (hop_limit_i != hops_ff);
    assign stale_sync = rx_sync_i && synced_o && (rx_epoch_i < tx_epoch_o);
    assign sync_ok = rx_sync_i && sleep_mode && !stale_sync;

    ////////////////////////////////////////////////////////////////////////
    // Configuration tracking

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cfg_sleep_ff <= PERIOD_RST;
            cfg_wake_ff <= PERIOD_RST;
            slots_ff <= 8'h00;
            hops_ff <= 8'h00;
            wake_eff_o <= PERIOD_RST;
        end
        else
        begin
            cfg_sleep_ff <= sleep_period_setting_i;
            cfg_wake_ff <= wake_time_setting_i;
            slots_ff <= delay_slot_count_i;
            hops_ff <= hop_limit_i;
            if (wake_time_setting_i < min_wake)
                wake_eff_o <= min_wake;
            else
                wake_eff_o <= wake_time_setting_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Coordinator role and network periods

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            coord_o <= 1'b0;
            pend_change_ff <= 1'b0;
            net_sleep_ff <= PERIOD_RST;
            net_wake_ff <= PERIOD_RST;
            tx_epoch_o <= 8'h00;
            synced_o <= 1'b0;
        end
        else
        begin
            if (sleep_options_i[OPT_PREF_COORD])
                coord_o <= 1'b1;
            else if (btn_double && !sleep_options_i[OPT_NON_COORD])
                coord_o <= 1'b1;
            if ((cfg_change || wake_time_setting_i != cfg_wake_ff) &&
                !sleep_options_i[OPT_NON_COORD] && sleep_mode)
            begin
                coord_o <= 1'b1;
                pend_change_ff <= 1'b1;
            end
            else if (tx_sync_o && pend_change_ff)
            begin
                pend_change_ff <= 1'b0;
                net_sleep_ff <= sleep_period_setting_i;
                net_wake_ff <= wake_eff_o;
                tx_epoch_o <= tx_epoch_o + 8'h01;
            end
            if (coord_o && !synced_o)
            begin
                synced_o <= 1'b1;
                net_sleep_ff <= sleep_period_setting_i;
                net_wake_ff <= wake_eff_o;
            end
            if (sync_ok)
            begin
                synced_o <= 1'b1;
                net_sleep_ff <= rx_sleep_i;
                net_wake_ff <= rx_wake_i;
                tx_epoch_o <= rx_epoch_i;
                if (!sleep_options_i[OPT_PREF_COORD])
                    coord_o <= 1'b0;
            end
            if (!sleep_mode)
            begin
                synced_o <= 1'b0;
                coord_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Missed sync counter

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            missed_o <= MISSED_RST;
        else if (sync_ok || coord_o)
            missed_o <= MISSED_RST;
        else if (state_ff == SSS_WAKE && timer_ff <= 16'h0001 &&
                 ms_tick && !sync_seen_ff && missed_o != 8'hff)
            missed_o <= missed_o + 8'h01;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            guard_o <= 16'h0000;
        else
            guard_o <= guard;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sleep and wake sequencer

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_ff <= SSS_IDLE;
            timer_ff <= 16'h0000;
            stay_ff <= 16'h0000;
            sync_seen_ff <= 1'b0;
            tx_sync_o <= 1'b0;
            tx_req_o <= 1'b0;
            tx_sleep_o <= PERIOD_RST;
            tx_wake_o <= PERIOD_RST;
            awake_o <= 1'b1;
        end
        else
        begin
            tx_sync_o <= 1'b0;
            tx_req_o <= 1'b0;
            tx_sleep_o <= pend_change_ff ? sleep_period_setting_i :
                          net_sleep_ff;
            tx_wake_o <= pend_change_ff ? wake_eff_o : net_wake_ff;
            if (sync_ok)
                sync_seen_ff <= 1'b1;
            if ((rx_req_i && synced_o && awake_o) || stale_sync)
                tx_sync_o <= 1'b1;
            unique case (state_ff)
                SSS_IDLE:
                begin
                    awake_o <= 1'b1;
                    if (sleep_mode)
                    begin
                        state_ff <= SSS_WAKE;
                        timer_ff <= wake_eff_o;
                        tx_req_o <= !synced_o && !coord_o;
                    end
                end
                SSS_WAKE:
                begin
                    awake_o <= 1'b1;
                    if (timer_ff == wake_eff_o && coord_o && ms_tick)
                        tx_sync_o <= 1'b1;
                    if (ms_tick)
                    begin
                        if (timer_ff > 16'h0001)
                            timer_ff <= timer_ff - 16'h0001;
                        else if (sleep_mode_select_i == MODE_SUPPORT)
                        begin
                            timer_ff <= synced_o ? net_wake_ff : wake_eff_o;
                            sync_seen_ff <= 1'b0;
                        end
                        else
                        begin
                            state_ff <= SSS_SLEEP;
                            awake_o <= 1'b0;
                            timer_ff <= synced_o ? sleep_len :
                                        sleep_period_setting_i;
                        end
                    end
                end
                SSS_SLEEP:
                begin
                    if (btn_hold)
                    begin
                        state_ff <= SSS_AWAKE;
                        stay_ff <= STAY_AWAKE_T;
                        awake_o <= 1'b1;
                    end
                    else if (btn_single && synced_o)
                    begin
                        state_ff <= SSS_AWAKE;
                        stay_ff <= STAY_AWAKE_T;
                        awake_o <= 1'b1;
                    end
                    else if (ms_tick && timer_ff <= 16'h0001)
                    begin
                        state_ff <= SSS_WAKE;
                        awake_o <= 1'b1;
                        sync_seen_ff <= 1'b0;
                        timer_ff <= synced_o ? net_wake_ff : wake_eff_o;
                        tx_req_o <= !synced_o ||
                            (sleep_options_i[OPT_NON_COORD] &&
                             missed_o >= 8'h06);
                    end
                    else if (ms_tick)
                        timer_ff <= timer_ff - 16'h0001;
                end
                SSS_AWAKE:
                begin
                    awake_o <= 1'b1;
                    if (ms_tick)
                    begin
                        if (stay_ff <= 16'h0001)
                        begin
                            state_ff <= SSS_SLEEP;
                            awake_o <= 1'b0;
                        end
                        else
                            stay_ff <= stay_ff - 16'h0001;
                    end
                end
            endcase
            if (!sleep_mode)
                state_ff <= SSS_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Association LED

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            led_cnt_ff <= 16'h0000;
            led_o <= 1'b0;
        end
        else if (!(coord_o || (synced_o && awake_o)))
        begin
            led_cnt_ff <= 16'h0000;
            led_o <= 1'b0;
        end
        else if (ms_tick)
        begin
            if (led_cnt_ff >= (coord_o ? LED_SLOW_MS : LED_FAST_MS))
            begin
                led_cnt_ff <= 16'h0000;
                led_o <= ~led_o;
            end
            else
                led_cnt_ff <= led_cnt_ff + 16'h0001;
        end
    end

endmodule : sss_sched

// ===== test/sss_peer.sv
// Peer node model sending sync messages and sync requests
`timescale 1ns/1ps
module sss_peer
    import sss_pkg::*;
(
    // Clock
    input wire logic mclk_i,
    // Radio events toward the node
    output logic rx_sync_o,
    output logic [15:0] rx_sleep_o,
    output logic [15:0] rx_wake_o,
    output logic [7:0] rx_epoch_o,
    output logic rx_req_o
);
    initial
    begin
        rx_sync_o = 1'b0;
        rx_req_o = 1'b0;
        rx_sleep_o = 16'ha5a5;
        rx_wake_o = 16'h5a5a;
        rx_epoch_o = 8'h3c;
    end

    ////////////////////////////////////////////////////////////////////
    // Sync after a chosen delay; fields scrambled outside the pulse
    task automatic send_sync(input logic [15:0] sl, input logic [15:0] wk,
        input logic [7:0] ep, input int dly);
        repeat (dly + 1) @(posedge mclk_i);
        rx_sync_o <= 1'b1;
        rx_sleep_o <= sl;
        rx_wake_o <= wk;
        rx_epoch_o <= ep;
        @(posedge mclk_i);
        rx_sync_o <= 1'b0;
        rx_sleep_o <= ~sl;
        rx_wake_o <= ~wk;
        rx_epoch_o <= ~ep;
    endtask : send_sync

    task automatic send_req(input int dly);
        repeat (dly + 1) @(posedge mclk_i);
        rx_req_o <= 1'b1;
        @(posedge mclk_i);
        rx_req_o <= 1'b0;
    endtask : send_req
endmodule : sss_peer

// ===== test/sss_sched_asserts.sv
// Port checker for the sleep sync scheduler
`timescale 1ns/1ps
module sss_sched_asserts
    import sss_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Configuration
    input wire logic [3:0] sleep_mode_select_i,
    input wire logic [7:0] sleep_options_i,
    input wire logic [15:0] sleep_period_setting_i,
    input wire logic [15:0] wake_time_setting_i,
    input wire logic [7:0] delay_slot_count_i,
    input wire logic [7:0] hop_limit_i,
    input wire logic [3:0] broadcast_repeat_count_i,
    // Radio events and button
    input wire logic rx_sync_i,
    input wire logic [15:0] rx_sleep_i,
    input wire logic [15:0] rx_wake_i,
    input wire logic [7:0] rx_epoch_i,
    input wire logic rx_req_i,
    input wire logic button_i,
    // Transmit requests
    input wire logic tx_sync_o,
    input wire logic tx_req_o,
    input wire logic [15:0] tx_sleep_o,
    input wire logic [15:0] tx_wake_o,
    input wire logic [7:0] tx_epoch_o,
    // Status
    input wire logic awake_o,
    input wire logic coord_o,
    input wire logic synced_o,
    input wire logic led_o,
    input wire logic [15:0] wake_eff_o,
    input wire logic [15:0] guard_o,
    input wire logic [7:0] missed_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    logic norm_m;
    logic [31:0] min_wake;
    logic [15:0] exp_wake;
    logic [51:0] cfg;
    assign norm_m = sleep_mode_select_i != MODE_SUPPORT
        && sleep_mode_select_i != MODE_CYCLIC;
    assign min_wake = delay_slot_count_i * hop_limit_i
        * (broadcast_repeat_count_i + 32'h1) * PROP_UNIT_MS;
    assign exp_wake = (32'(wake_time_setting_i) < min_wake)
        ? min_wake[15:0] : wake_time_setting_i;
    assign cfg = {sleep_period_setting_i, wake_time_setting_i,
        delay_slot_count_i, hop_limit_i, broadcast_repeat_count_i};

    ////////////////////////////////////////////////////////////////////
    a_req_answered: assert property (
        rx_req_i && synced_o && awake_o |=> tx_sync_o
    ) else $error("sync request not answered");
    a_stale_fixed: assert property (
        rx_sync_i && synced_o && awake_o && rx_epoch_i < tx_epoch_o
        && sleep_mode_select_i == MODE_SUPPORT |=> tx_sync_o
    ) else $error("outdated sync not corrected");
    a_support_awake: assert property (
        sleep_mode_select_i == MODE_SUPPORT
        && $past(sleep_mode_select_i) == MODE_SUPPORT |-> awake_o
    ) else $error("support node asleep");
    a_normal_quiet: assert property (
        norm_m && $past(norm_m) && !$past(synced_o)
        |-> !synced_o && !tx_req_o
    ) else $error("normal mode joined sync");
    a_sync_clears: assert property (
        rx_sync_i && awake_o && !norm_m && !coord_o
        && rx_epoch_i == tx_epoch_o |=> missed_o == MISSED_RST && synced_o
    ) else $error("accepted sync left missed count");
    a_guard_tracks: assert property (
        (missed_o != MISSED_RST && $stable(missed_o))[*3]
        |-> guard_o == GUARD_BASE_MS + GUARD_STEP_MS * missed_o
    ) else $error("guard time off");
    a_wake_min: assert property (
        $stable(cfg)[*3] |-> wake_eff_o == exp_wake
    ) else $error("wake time not raised to minimum");
    a_led_sleep: assert property (
        !coord_o && !awake_o && !$past(coord_o) && !$past(awake_o)
        |-> !led_o
    ) else $error("led on while asleep");
    a_noncoord_stays: assert property (
        sleep_options_i[OPT_NON_COORD] && !sleep_options_i[OPT_PREF_COORD]
        && !$past(coord_o) |-> !coord_o
    ) else $error("non coordinator took over");
    a_unsync_request: assert property (
        $changed(sleep_mode_select_i) && sleep_mode_select_i == MODE_CYCLIC
        && !synced_o && !sleep_options_i[OPT_PREF_COORD] |-> ##[1:2] tx_req_o
    ) else $error("no sync request");

    c_coord_sync: cover property (coord_o && tx_sync_o);
    c_stale: cover property (rx_sync_i && rx_epoch_i < tx_epoch_o);
    c_missed: cover property (missed_o != MISSED_RST);
endmodule : sss_sched_asserts

bind sss_sched sss_sched_asserts sss_sched_asserts_i (.*);

// ===== test/sss_sched_tb_top.sv
// Self-checking bench for the sleep sync scheduler
`timescale 1ns/1ps
module sss_sched_tb_top
    import sss_pkg::*;
;
    localparam int MS = MS_CYCLES;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] sleep_mode_select_i = MODE_NORMAL;
    logic [7:0] sleep_options_i = 8'h00;
    logic [15:0] sleep_period_setting_i = 16'h0001;
    logic [15:0] wake_time_setting_i = 16'h0001;
    logic [7:0] delay_slot_count_i = 8'h00;
    logic [7:0] hop_limit_i = 8'h01;
    logic [3:0] broadcast_repeat_count_i = 4'h0;
    logic button_i = 1'b0;
    logic rx_sync_i, rx_req_i, tx_sync_o, tx_req_o;
    logic awake_o, coord_o, synced_o, led_o;
    logic [15:0] rx_sleep_i, rx_wake_i, tx_sleep_o, tx_wake_o;
    logic [15:0] wake_eff_o, guard_o;
    logic [7:0] rx_epoch_i, tx_epoch_o, missed_o;
    int n_fail = 0;
    int n_tests = 0;
    int n_txs = 0, n_txr = 0, g1, g2;

    always #50 mclk_i = ~mclk_i;

    sss_sched sss_sched_i (.*);
    sss_peer sss_peer_i (
        .mclk_i(mclk_i),
        .rx_sync_o(rx_sync_i),
        .rx_sleep_o(rx_sleep_i),
        .rx_wake_o(rx_wake_i),
        .rx_epoch_o(rx_epoch_i),
        .rx_req_o(rx_req_i)
    );

    always @(posedge mclk_i)
    begin
        if (tx_sync_o === 1'b1)
            n_txs++;
        if (tx_req_o === 1'b1)
            n_txr++;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: flag %b not %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: value %0h not %0h", $time, got, exp);
        end
    endtask : chk_val

    function automatic logic hit(input int sel);
        case (sel)
            0: return tx_req_o;
            1: return tx_sync_o;
            2: return awake_o;
            3: return !awake_o;
            4: return coord_o;
            default: return missed_o != MISSED_RST;
        endcase
    endfunction : hit

    task automatic wait_on(input int sel, input int lim, output int n);
        n = 0;
        #1;
        while (hit(sel) !== 1'b1 && n < lim)
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk_bit(hit(sel), 1'b1);
    endtask : wait_on

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tick

    task automatic do_reset(input logic [3:0] mode, input logic [7:0] opt);
        @(posedge mclk_i);
        nrst_i <= 1'b0;
        sleep_mode_select_i <= mode;
        sleep_options_i <= opt;
        sleep_period_setting_i <= 16'h0001;
        tick(5);
        nrst_i <= 1'b1;
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////
    task automatic t_config;
        #1;
        chk_bit(awake_o, 1'b1);
        chk_bit(synced_o, 1'b0);
        @(posedge mclk_i);
        delay_slot_count_i <= 8'h02;
        hop_limit_i <= 8'h03;
        broadcast_repeat_count_i <= 4'h1;
        wake_time_setting_i <= 16'h000a;
        tick(4);
        chk_val(wake_eff_o, 16'(12 * PROP_UNIT_MS));
        wake_time_setting_i <= 16'h012c;
        tick(4);
        chk_val(wake_eff_o, 16'h012c);
        delay_slot_count_i <= 8'h00;
        wake_time_setting_i <= 16'h0001;
        tick(4);
        chk_val(wake_eff_o, 16'h0001);
    endtask : t_config

    task automatic t_normal;
        sleep_options_i <= 8'h02;
        sss_peer_i.send_sync(16'h0001, 16'h0001, 8'h00, 0);
        sss_peer_i.send_req(2);
        tick(3);
        #1;
        chk_bit(synced_o, 1'b0);
        chk_val(16'(n_txs + n_txr), 16'h0000);
    endtask : t_normal

    task automatic t_join;
        @(posedge mclk_i);
        sleep_mode_select_i <= MODE_CYCLIC;
        wait_on(0, 5, g1);
        wait_on(3, 3 * MS, g1);
        wait_on(0, 3 * MS, g2);
        chk_bit(g1 + g2 >= MS && g1 + g2 <= 3 * MS, 1'b1);
        sss_peer_i.send_sync(16'h0001, 16'h0001, 8'h00, 2);
        tick(1);
        #1;
        chk_bit(synced_o, 1'b1);
        chk_val(16'(missed_o), 16'h0000);
        g2 = n_txr;
        sss_peer_i.send_req(0);
        wait_on(1, 3, g1);
        chk_val(tx_sleep_o, 16'h0001);
        chk_val(tx_wake_o, 16'h0001);
        wait_on(5, 5 * MS, g1);
        tick(2);
        #1;
        chk_val(16'(missed_o), 16'h0001);
        chk_val(guard_o, GUARD_BASE_MS + GUARD_STEP_MS);
        chk_val(16'(n_txr - g2), 16'h0000);
        wait_on(3, 3 * MS, g1);
        tick(2);
        #1;
        chk_bit(led_o, 1'b0);
        wait_on(2, 3 * MS, g1);
        sss_peer_i.send_sync(16'h0001, 16'h0001, 8'h00, 1);
        tick(1);
        #1;
        chk_val(16'(missed_o), 16'h0000);
    endtask : t_join

    task automatic t_support;
        do_reset(MODE_SUPPORT, 8'h00);
        sss_peer_i.send_sync(16'h0001, 16'h0001, 8'h00, 0);
        tick(2);
        #1;
        chk_bit(synced_o, 1'b1);
        @(posedge mclk_i);
        sleep_period_setting_i <= 16'h0003;
        wait_on(4, 3 * MS, g1);
        wait_on(1, 5 * MS, g1);
        chk_val(tx_sleep_o, 16'h0003);
        chk_val(tx_wake_o, 16'h0001);
        tick(1);
        #1;
        chk_val(16'(tx_epoch_o), 16'h0001);
        sss_peer_i.send_sync(16'h0001, 16'h0001, 8'h00, 3);
        wait_on(1, 3, g1);
        chk_val(tx_sleep_o, 16'h0003);
        chk_bit(awake_o, 1'b1);
    endtask : t_support

    task automatic t_pref;
        do_reset(MODE_CYCLIC, 8'h01);
        wait_on(1, 5 * MS, g1);
        chk_bit(coord_o, 1'b1);
        wait_on(3, 3 * MS, g1);
        wait_on(1, 5 * MS, g1);
    endtask : t_pref

    task automatic end_sim;
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    initial
    begin
        do_reset(MODE_NORMAL, 8'h00);
        t_config;
        t_normal;
        t_join;
        t_support;
        t_pref;
        end_sim;
    end

    initial
    begin
        #20_000_000;
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_sim;
    end
endmodule : sss_sched_tb_top
